// >>> rtl/env_translation_defs.vh
// Offsets, field positions, reset values and encodings of the two supervisor registers
`ifndef ENV_TRANSLATION_DEFS_VH
`define ENV_TRANSLATION_DEFS_VH

// ==========================================================
// Register byte offsets (32-bit APB words)
`define ENVCFG_LO_OFF 12'h000
`define ENVCFG_HI_OFF 12'h004
`define XLAT_LO_OFF 12'h008
`define XLAT_HI_OFF 12'h00c
`define XLAT_STAGE_LO_OFF 12'h010
`define XLAT_STAGE_HI_OFF 12'h014
`define HART_CTRL_OFF 12'h018
`define HART_STATUS_OFF 12'h01c

// ==========================================================
// Environment configuration fields
`define ENV_FENCE_MEM_BIT 0
`define ENV_PAD_EN_BIT 2
`define ENV_STACK_EN_BIT 3
`define ENV_BLK_INV_LO 4
`define ENV_BLK_INV_HI 5
`define ENV_BLK_CLEAN_BIT 6
`define ENV_BLK_ZERO_BIT 7
`define ENV_PTR_MASK_LO 32
`define ENV_PTR_MASK_HI 33
`define ENV_WMASK 64'h0000_0003_0000_00fd
`define ENV_RESET 64'h0000_0000_0000_0000

// ==========================================================
// Translation control fields
`define XLAT_MODE_LO 60
`define XLAT_MODE_HI 63
`define XLAT_SPACE_ID_LO 44
`define XLAT_SPACE_ID_HI 59
`define XLAT_ROOT_LO 0
`define XLAT_ROOT_HI 43
`define XLAT_RESET 64'h0000_0000_0000_0000
`define SPACE_ID_LEN 16
`define SPACE_ID_MASK 16'hffff

// ==========================================================
// Scheme selector encodings
`define MODE_BARE 4'h0
`define MODE_PAGED39 4'h8
`define MODE_PAGED48 4'h9
`define MODE_PAGED57 4'ha

// ==========================================================
// Privilege encodings
`define PRIV_U 2'h0
`define PRIV_S 2'h1
`define PRIV_M 2'h3

`endif

// >>> rtl/supervisor_env_and_translation_csrs.v
// Supervisor environment-configuration and address-translation control registers over APB
`timescale 1ns/100ps
`include "env_translation_defs.vh"

module supervisor_env_and_translation_csrs (
    // APB slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Hart execution context
    input wire [1:0] priv_mode,
    input wire virt_mode,
    input wire machine_stack_enable,
    input wire user_fence_pi,
    input wire user_fence_po,
    input wire user_fence_si,
    input wire user_fence_so,
    input wire user_amo_device,
    input wire user_amo_acquire_bit,
    input wire user_amo_release_bit,
    input wire landing_pad_expect_req,
    // Effects on the hart
    output reg pred_memory_read,
    output reg pred_memory_write,
    output reg succ_memory_read,
    output reg succ_memory_write,
    output reg amo_order_memory,
    output reg expected_landing_pad_state,
    output reg landing_pad_as_noop,
    output reg stack_insn_as_mop,
    output reg stack_swap_illegal,
    output reg stack_swap_virtual,
    output reg translation_active,
    output reg translation_bypass,
    output reg [3:0] active_mode,
    output reg [15:0] active_space_id,
    output reg [43:0] active_root_page
);

// ==========================================================
// Registers
reg [63:0] envcfg_r;
reg [63:0] xlat_r;
reg [31:0] xlat_stage_lo_r;
reg [31:0] xlat_stage_hi_r;
reg [1:0] priv_meta_r;
reg [1:0] priv_sync_r;
reg virt_meta_r;
reg virt_sync_r;
reg mstack_meta_r;
reg mstack_sync_r;

// ==========================================================
// Next-state values
reg [63:0] envcfg_nxt;
reg [63:0] xlat_nxt;
reg [31:0] rdata_nxt;
reg err_nxt;
reg [63:0] xlat_cand;
reg mode_ok;

// ==========================================================
// Bus decode and live fields
wire access = psel && penable && !pready;
wire wr = access && pwrite;
wire user_ctx = (priv_sync_r == `PRIV_U);
wire super_ctx = (priv_sync_r == `PRIV_S);
wire [63:0] env_wmask = `ENV_WMASK;
// Fence bit kept writable since the selector is not hardwired to none
wire fence_io_implies_memory = envcfg_r[`ENV_FENCE_MEM_BIT];
wire landing_pad_enable = envcfg_r[`ENV_PAD_EN_BIT];
wire shadow_stack_enable = envcfg_r[`ENV_STACK_EN_BIT];
wire [3:0] xlat_mode_now = xlat_r[`XLAT_MODE_HI:`XLAT_MODE_LO];
wire [3:0] fence_req = {user_fence_so, user_fence_si, user_fence_po, user_fence_pi};
wire [3:0] fence_mem_nxt;

// ==========================================================
// Pin synchronisers; hart context comes from another block
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        priv_meta_r <= 2'h0;
        priv_sync_r <= 2'h0;
    end
    else
    begin
        priv_meta_r <= priv_mode;
        priv_sync_r <= priv_meta_r;
    end
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        virt_meta_r <= 1'b0;
        virt_sync_r <= 1'b0;
    end
    else
    begin
        virt_meta_r <= virt_mode;
        virt_sync_r <= virt_meta_r;
    end
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        mstack_meta_r <= 1'b0;
        mstack_sync_r <= 1'b0;
    end
    else
    begin
        mstack_meta_r <= machine_stack_enable;
        mstack_sync_r <= mstack_meta_r;
    end
end

// ==========================================================
// Scheme check; 64-bit hart only, so 32-bit selections are not decoded
function scheme_supported;
    input [3:0] m;
    begin
        case (m)
            `MODE_BARE, `MODE_PAGED39, `MODE_PAGED48, `MODE_PAGED57:
                scheme_supported = 1'b1;
            default: scheme_supported = 1'b0;
        endcase
    end
endfunction

// ==========================================================
// Fence widening, one lane per device-ordering bit
genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_fence
        assign fence_mem_nxt[gi] =
            user_ctx && fence_io_implies_memory && fence_req[gi];
    end
endgenerate

// ==========================================================
// Register writes and reads
always @*
begin
    envcfg_nxt = envcfg_r;
    xlat_nxt = xlat_r;
    rdata_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    xlat_cand = {pwdata, xlat_stage_lo_r};
    mode_ok = scheme_supported(xlat_cand[`XLAT_MODE_HI:`XLAT_MODE_LO]);
    if (access)
    begin
        case (paddr)
            `ENVCFG_LO_OFF:
            begin
                if (pwrite)
                    envcfg_nxt[31:0] = pwdata & env_wmask[31:0];
                rdata_nxt = envcfg_r[31:0];
            end
            `ENVCFG_HI_OFF:
            begin
                if (pwrite)
                    envcfg_nxt[63:32] = pwdata & env_wmask[63:32];
                rdata_nxt = envcfg_r[63:32];
            end
            `XLAT_LO_OFF:
                rdata_nxt = xlat_r[31:0];
            `XLAT_HI_OFF:
            begin
                // High word commits the staged low word in one update
                if (pwrite && mode_ok)
                begin
                    xlat_nxt = xlat_cand;
                    xlat_nxt[`XLAT_SPACE_ID_HI:`XLAT_SPACE_ID_LO] =
                        xlat_cand[`XLAT_SPACE_ID_HI:`XLAT_SPACE_ID_LO] & `SPACE_ID_MASK;
                    // Bare with nonzero fields is reserved; keep them zeroed
                    if (xlat_cand[`XLAT_MODE_HI:`XLAT_MODE_LO] == `MODE_BARE)
                        xlat_nxt[59:0] = 60'h000_0000_0000_0000;
                end
                else if (pwrite)
                    err_nxt = 1'b1;
                rdata_nxt = xlat_r[63:32];
            end
            `XLAT_STAGE_LO_OFF:
                rdata_nxt = xlat_stage_lo_r;
            `XLAT_STAGE_HI_OFF:
                rdata_nxt = xlat_stage_hi_r;
            `HART_CTRL_OFF:
                rdata_nxt = {30'h0000_0000, virt_sync_r, mstack_sync_r};
            `HART_STATUS_OFF:
                rdata_nxt = {27'h000_0000, expected_landing_pad_state, translation_active,
                    translation_bypass, priv_sync_r};
            default:
                err_nxt = 1'b1;
        endcase
    end
end

// ==========================================================
// Environment register
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        envcfg_r <= `ENV_RESET;
    end
    else
    begin
        envcfg_r <= envcfg_nxt;
    end
end

// ==========================================================
// Translation register, changed only by a whole accepted commit
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        xlat_r <= `XLAT_RESET;
    end
    else
    begin
        xlat_r <= xlat_nxt;
    end
end

// ==========================================================
// Staging words; a rejected commit still leaves its word visible here
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        xlat_stage_lo_r <= 32'h0000_0000;
        xlat_stage_hi_r <= 32'h0000_0000;
    end
    else
    begin
        if (wr && paddr == `XLAT_LO_OFF)
            xlat_stage_lo_r <= pwdata;
        if (wr && paddr == `XLAT_HI_OFF)
            xlat_stage_hi_r <= pwdata;
    end
end

// ==========================================================
// Bus answer; one wait state, every response registered
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata <= 32'h0000_0000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
    else
    begin
        prdata <= rdata_nxt;
        pready <= access;
        pslverr <= err_nxt;
    end
end

// ==========================================================
// Ordering effects, registered for clean outputs
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pred_memory_read <= 1'b0;
        pred_memory_write <= 1'b0;
        succ_memory_read <= 1'b0;
        succ_memory_write <= 1'b0;
        amo_order_memory <= 1'b0;
    end
    else
    begin
        // Fence widening only in user mode
        pred_memory_read <= fence_mem_nxt[0];
        pred_memory_write <= fence_mem_nxt[1];
        succ_memory_read <= fence_mem_nxt[2];
        succ_memory_write <= fence_mem_nxt[3];
        amo_order_memory <= user_ctx && fence_io_implies_memory && user_amo_device
            && (user_amo_acquire_bit || user_amo_release_bit);
    end
end

// ==========================================================
// Landing-pad and shadow-stack effects
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        expected_landing_pad_state <= 1'b0;
        landing_pad_as_noop <= 1'b1;
        stack_insn_as_mop <= 1'b1;
        stack_swap_illegal <= 1'b0;
        stack_swap_virtual <= 1'b0;
    end
    else
    begin
        expected_landing_pad_state <= user_ctx && landing_pad_enable
            && landing_pad_expect_req;
        landing_pad_as_noop <= !landing_pad_enable;
        stack_insn_as_mop <= !shadow_stack_enable;
        stack_swap_illegal <= user_ctx && !shadow_stack_enable && mstack_sync_r
            && !virt_sync_r;
        stack_swap_virtual <= user_ctx && !shadow_stack_enable && mstack_sync_r
            && virt_sync_r;
    end
end

// ==========================================================
// Translation copy seen by the walker
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        translation_active <= 1'b0;
        translation_bypass <= 1'b1;
        active_mode <= `MODE_BARE;
        active_space_id <= 16'h0000;
        active_root_page <= 44'h000_0000_0000;
    end
    else
    begin
        translation_active <= super_ctx || user_ctx;
        translation_bypass <= (xlat_mode_now == `MODE_BARE);
        // New mode, space ID and root reach the copy only while active; translation_bypass follows the register mode in every context
        if (super_ctx || user_ctx)
        begin
            active_mode <= xlat_mode_now;
            active_space_id <= xlat_r[`XLAT_SPACE_ID_HI:`XLAT_SPACE_ID_LO];
            active_root_page <= xlat_r[`XLAT_ROOT_HI:`XLAT_ROOT_LO];
        end
    end
end

endmodule // supervisor_env_and_translation_csrs

// >>> tb/env_csr_chk.sv
// Checker for the supervisor environment and translation registers
`timescale 1ns/100ps
module env_csr_chk (
    // Clock, reset and bus answer
    input logic pclk, presetn, pready, pslverr,
    // Hart context
    input logic user_fence_pi, user_fence_po, user_fence_si, user_fence_so,
    input logic user_amo_device, user_amo_acquire_bit, user_amo_release_bit,
    // Effects
    input logic pred_memory_read, pred_memory_write, succ_memory_read, succ_memory_write,
    input logic amo_order_memory, expected_landing_pad_state, landing_pad_as_noop,
    input logic stack_insn_as_mop, stack_swap_illegal, stack_swap_virtual, translation_active,
    input logic [3:0] active_mode,
    input logic [15:0] active_space_id,
    input logic [43:0] active_root_page
);
    // ==========================================================
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pred_read: assert property (pred_memory_read |-> $past(user_fence_pi))
        else $error("pred read without device input");
    a_pred_write: assert property (pred_memory_write |-> $past(user_fence_po))
        else $error("pred write without device output");
    a_succ_both: assert property ((succ_memory_read |-> $past(user_fence_si))
        and (succ_memory_write |-> $past(user_fence_so))) else $error("succ set without cause");
    a_amo_order: assert property (amo_order_memory |-> $past(user_amo_device)
        && ($past(user_amo_acquire_bit) || $past(user_amo_release_bit)))
        else $error("atomic ordered without cause");
    a_pad_idle: assert property (landing_pad_as_noop |-> !expected_landing_pad_state)
        else $error("pad expected while disabled");
    a_swap_fault: assert property (stack_swap_illegal || stack_swap_virtual |->
        stack_insn_as_mop && !(stack_swap_illegal && stack_swap_virtual))
        else $error("swap fault while stack enabled");
    // Checked over two idle cycles; the copy enable and the flag are set on the same edge from the same condition
    a_idle_hold: assert property (!translation_active ##1 !translation_active |->
        $stable(active_mode) && $stable(active_space_id) && $stable(active_root_page))
        else $error("translation copy moved while inactive");
    a_mode_legal: assert property (active_mode inside {4'h0, 4'h8, 4'h9, 4'ha})
        else $error("unsupported scheme active");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held");
endmodule // env_csr_chk

// >>> tb/test_supervisor_env_and_translation_csrs.sv
// Self-checking bench for the supervisor environment and translation registers
`timescale 1ns/100ps
`include "env_translation_defs.vh"
module test_supervisor_env_and_translation_csrs;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, virt_mode, machine_stack_enable;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0] priv_mode;
    logic user_fence_pi, user_fence_po, user_fence_si, user_fence_so, user_amo_device;
    logic user_amo_acquire_bit, user_amo_release_bit, landing_pad_expect_req, pred_memory_read;
    logic pred_memory_write, succ_memory_read, succ_memory_write, amo_order_memory;
    logic expected_landing_pad_state, landing_pad_as_noop, stack_insn_as_mop, stack_swap_illegal;
    logic stack_swap_virtual, translation_active, translation_bypass;
    logic [3:0] active_mode;
    logic [15:0] active_space_id;
    logic [43:0] active_root_page;
    int error_cnt = 0;
    int total_checks = 0;
    // High word commits the staged low word
    localparam logic [11:0] xl_lo = 12'h008;
    localparam logic [11:0] xl_hi = 12'h00c;
    localparam logic [11:0] ev_lo = `ENVCFG_LO_OFF;
    supervisor_env_and_translation_csrs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .priv_mode, .virt_mode, .machine_stack_enable,
        .user_fence_pi, .user_fence_po, .user_fence_si, .user_fence_so, .user_amo_device,
        .user_amo_acquire_bit, .user_amo_release_bit, .landing_pad_expect_req,
        .pred_memory_read, .pred_memory_write, .succ_memory_read, .succ_memory_write,
        .amo_order_memory, .expected_landing_pad_state, .landing_pad_as_noop, .stack_insn_as_mop,
        .stack_swap_illegal, .stack_swap_virtual, .translation_active, .translation_bypass,
        .active_mode, .active_space_id, .active_root_page);
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // ==========================================================
    // Shared tasks
    task report_and_stop;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // For reads d is the expected word
    task bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic eerr);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1)
        begin
            error_cnt++;
            $display("ERROR %0t no ready", $time);
            report_and_stop;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        chk(pslverr, eerr);
        if (!wr)
            chk(prdata, d);
    endtask
    // Context inputs pass a two-stage synchroniser
    task ctx(input logic [1:0] p, input logic v, input logic m);
        @(posedge pclk);
        priv_mode <= p;
        virt_mode <= v;
        machine_stack_enable <= m;
        repeat (5) @(posedge pclk);
    endtask
    // ==========================================================
    // Scenarios
    task t_env;
        bus(0, ev_lo, 32'h0, 1'b0);
        bus(0, xl_hi, 32'h0, 1'b0);
        chk({translation_bypass, landing_pad_as_noop, stack_insn_as_mop}, 3'h7);
        bus(1, ev_lo, 32'hffff_ffff, 1'b0);
        bus(1, `ENVCFG_HI_OFF, 32'hffff_ffff, 1'b0);
        bus(0, ev_lo, 32'h0000_00fd, 1'b0);
        bus(0, `ENVCFG_HI_OFF, 32'h0000_0003, 1'b0);
        bus(1, 12'h100, 32'h0, 1'b1);
    endtask
    task t_fence;
        ctx(2'h0, 1'b0, 1'b0);
        bus(1, ev_lo, 32'h1, 1'b0);
        user_fence_pi <= 1'b1;
        user_fence_so <= 1'b1;
        user_amo_device <= 1'b1;
        user_amo_release_bit <= 1'b1;
        repeat (2) @(posedge pclk);
        chk({pred_memory_read, pred_memory_write, succ_memory_read, succ_memory_write}, 4'h9);
        chk(amo_order_memory, 1'b1);
        user_fence_pi <= 1'b0;
        user_fence_po <= 1'b1;
        user_fence_si <= 1'b1;
        user_fence_so <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({pred_memory_read, pred_memory_write, succ_memory_read, succ_memory_write}, 4'h6);
        bus(1, ev_lo, 32'h0, 1'b0);
        repeat (2) @(posedge pclk);
        chk({pred_memory_write, succ_memory_read, amo_order_memory}, 3'h0);
    endtask
    task t_pad_stack;
        ctx(2'h0, 1'b0, 1'b1);
        landing_pad_expect_req <= 1'b1;
        bus(1, ev_lo, 32'h4, 1'b0);
        repeat (2) @(posedge pclk);
        chk({expected_landing_pad_state, landing_pad_as_noop}, 2'h2);
        chk({stack_insn_as_mop, stack_swap_illegal, stack_swap_virtual}, 3'h6);
        ctx(2'h0, 1'b1, 1'b1);
        chk({stack_swap_illegal, stack_swap_virtual}, 2'h1);
        bus(0, `HART_CTRL_OFF, 32'h0000_0003, 1'b0);
        bus(1, ev_lo, 32'h8, 1'b0);
        repeat (2) @(posedge pclk);
        chk({expected_landing_pad_state, stack_insn_as_mop, stack_swap_virtual}, 3'h0);
    endtask
    task t_translate;
        ctx(2'h1, 1'b0, 1'b0);
        bus(1, xl_lo, 32'h1234_5678, 1'b0);
        bus(0, xl_lo, 32'h0, 1'b0);
        bus(0, `XLAT_STAGE_LO_OFF, 32'h1234_5678, 1'b0);
        bus(1, xl_hi, 32'h8fff_fabc, 1'b0);
        for (int m = 1; m < 16; m++)
            if (m < 8 || m > 10)
                bus(1, xl_hi, {m[3:0], 28'h0}, 1'b1);
        bus(0, xl_hi, 32'h8fff_fabc, 1'b0);
        bus(0, xl_lo, 32'h1234_5678, 1'b0);
        repeat (2) @(posedge pclk);
        chk({active_mode, active_space_id, active_root_page}, 64'h8fff_fabc_1234_5678);
        chk(translation_bypass, 1'b0);
        bus(0, `HART_STATUS_OFF, 32'h0000_0009, 1'b0);
        ctx(2'h3, 1'b0, 1'b0);
        chk(translation_active, 1'b0);
        bus(1, xl_hi, 32'h9000_0001, 1'b0);
        repeat (2) @(posedge pclk);
        chk(active_mode, 4'h8);
        ctx(2'h1, 1'b0, 1'b0);
        chk({active_mode, active_space_id, active_root_page}, 64'h9000_0001_1234_5678);
        bus(1, xl_hi, 32'ha000_0000, 1'b0);
        bus(1, xl_lo, 32'h0, 1'b0);
        bus(1, xl_hi, 32'h0, 1'b0);
        repeat (2) @(posedge pclk);
        chk({translation_bypass, active_mode}, 5'h10);
        bus(1, xl_hi, 32'h0000_0005, 1'b0);
        bus(0, xl_hi, 32'h0, 1'b0);
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, priv_mode, virt_mode} = '0;
        {machine_stack_enable, user_fence_pi, user_fence_po, user_fence_si, user_fence_so} = '0;
        {user_amo_device, user_amo_acquire_bit, user_amo_release_bit, landing_pad_expect_req} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_env;
        t_fence;
        t_pad_stack;
        t_translate;
        report_and_stop;
    end
endmodule // test_supervisor_env_and_translation_csrs
bind supervisor_env_and_translation_csrs env_csr_chk chk_i (.pclk, .presetn, .pready, .pslverr,
    .user_fence_pi, .user_fence_po, .user_fence_si, .user_fence_so, .user_amo_device,
    .user_amo_acquire_bit, .user_amo_release_bit, .pred_memory_read, .pred_memory_write,
    .succ_memory_read, .succ_memory_write, .amo_order_memory, .expected_landing_pad_state,
    .landing_pad_as_noop, .stack_insn_as_mop, .stack_swap_illegal, .stack_swap_virtual,
    .translation_active, .active_mode, .active_space_id, .active_root_page);
